/* core/flash_seq_defines.vh */
// Constants for the serial flash command sequencer: opcodes, address fields,
// page geometry, phase lengths and timing.
// Assumes inclusion by bare name from the core/ directory.
`ifndef FLASH_SEQ_DEFINES_VH
`define FLASH_SEQ_DEFINES_VH

// ----------------------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------------------
`define OP_LOW_POWER_READ   8'h01
`define OP_PAGE_READ        8'hd2
`define OP_BUF_READ_FAST    8'hd4
`define OP_BUF_READ_SLOW    8'hd1
`define OP_BUF_WRITE        8'h84
`define OP_PROG_ERASE       8'h83

// ----------------------------------------------------------------------------
// Address field positions in the 24-bit address
// ----------------------------------------------------------------------------
`define PG264_MSB           18
`define PG264_LSB           9
`define OFF264_MSB          8
`define PG256_MSB           17
`define PG256_LSB           8
`define OFF256_MSB          7

// ----------------------------------------------------------------------------
// Geometry and phase lengths
// ----------------------------------------------------------------------------
`define LAST_OFF_264        9'h107
`define LAST_OFF_256        9'h0ff
`define BUF_DEPTH           264
`define ADDR_LAST_BYTE      2'h2
`define DUMMY_PAGE_READ     3'h4
`define DUMMY_BUF_FAST      3'h1
`define DUMMY_NONE          3'h0
`define ERASED_BYTE         8'hff

// ----------------------------------------------------------------------------
// Timing and reset values
// ----------------------------------------------------------------------------
`define MCLK_MHZ            25
`define EP_TIME_US          4000
`define SO_RESET            1'b0
`define CFG_256_RESET       1'b0

`endif

/* core/spi_pin_sync.v */
// Pin synchroniser for the flash sequencer: select, clock, serial input and
// page-size strap are brought into the mclk domain and clock edges found.
// Assumes the link clock is at least four mclk periods per half cycle.
`timescale 1ns/1ps

module spi_pin_sync (
  mclk,
  srst,
  cs_n,
  sck,
  si,
  cfg_256,
  cs_n_s,
  cs_rise,
  sck_rise,
  sck_fall,
  si_s,
  cfg_256_s
);
  input  wire mclk;
  input  wire srst;
  input  wire cs_n;
  input  wire sck;
  input  wire si;
  input  wire cfg_256;
  output wire cs_n_s;
  output wire cs_rise;
  output wire sck_rise;
  output wire sck_fall;
  output wire si_s;
  output wire cfg_256_s;

  reg [3:0] meta_reg;
  reg [3:0] sync_reg;
  reg       sck_d_reg;
  reg       cs_d_reg;

  // --------------------------------------------------------------------------
  // Two flops per pin; edges compare second stage against a third copy
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      meta_reg  <= 4'h5;
      sync_reg  <= 4'h5;
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      meta_reg  <= {cfg_256, si, sck, cs_n};
      sync_reg  <= meta_reg;
      sck_d_reg <= sync_reg[1];
      cs_d_reg  <= sync_reg[0];
    end
  end

  assign cs_n_s    = sync_reg[0];
  assign cs_rise   = sync_reg[0] & ~cs_d_reg;
  assign sck_rise  = sync_reg[1] & ~sck_d_reg & ~sync_reg[0];
  assign sck_fall  = ~sync_reg[1] & sck_d_reg & ~sync_reg[0];
  assign si_s      = sync_reg[2];
  assign cfg_256_s = sync_reg[3];

endmodule

/* core/flash_cmd_seq.v */
// Command decoder and sequencer of a serial flash slave: low-power array read,
// page read, buffer read and write, and buffer-to-page program with erase.
// Assumes an external page array with a one-cycle synchronous read port and
// a write port that reports a failed byte one cycle after the write strobe.
//
// Overview of operation
// - Opcode 01h, three address bytes, no dummies, then data streams out.
// - 264-byte mode: upper ten address bits pick page, low nine the byte.
// - 256-byte mode: 18-bit address, top ten bits page, low eight byte.
// - Array read passes page end into next page with no extra clocks.
// - Array read wraps from last array bit to first page without delay.
// - Select rising ends any read and floats the serial output.
// - Array and page reads never change the buffer contents.
// - Opcode D2h, three address bytes, four dummy bytes, then data.
// - Page read wraps from page end to byte zero of same page.
// - The array holds 1024 pages, any of them readable.
// - Buffer read accepts opcodes D4h and D1h.
// - D4h needs one dummy byte after address; D1h none.
// - Buffer read wraps from last buffer byte to first.
// - Opcode 84h plus address writes serial data into buffer from offset.
// - Buffer write keeps storing with wrap until select rises.
// - Select rise after 83h erases page to ones then programs buffer.
// - Busy is reported while erase and program run.
// - A byte failing erase or program sets the error flag.
`timescale 1ns/1ps
`include "flash_seq_defines.vh"

module flash_cmd_seq #(
  parameter EP_CYCLES = `EP_TIME_US * `MCLK_MHZ
) (
  mclk,
  srst,
  cs_n,
  sck,
  si,
  so,
  so_oe,
  page_size_256,
  array_addr,
  array_rd_en,
  array_rd_data,
  array_wr_en,
  array_wr_data,
  array_wr_fail,
  busy,
  erase_program_error_flag
);
  input  wire        mclk;
  input  wire        srst;
  input  wire        cs_n;
  input  wire        sck;
  input  wire        si;
  output wire        so;
  output wire        so_oe;
  input  wire        page_size_256;
  output wire [18:0] array_addr;
  output wire        array_rd_en;
  input  wire [7:0]  array_rd_data;
  output wire        array_wr_en;
  output wire [7:0]  array_wr_data;
  input  wire        array_wr_fail;
  output wire        busy;
  output wire        erase_program_error_flag;

  // --------------------------------------------------------------------------
  // Command phase and operation kinds
  // --------------------------------------------------------------------------
  localparam [2:0] ST_OPCODE = 3'h0;
  localparam [2:0] ST_ADDR   = 3'h1;
  localparam [2:0] ST_DUMMY  = 3'h2;
  localparam [2:0] ST_DATA   = 3'h3;
  localparam [2:0] ST_IGNORE = 3'h4;

  localparam [2:0] K_ARRAY   = 3'h0;
  localparam [2:0] K_PAGE    = 3'h1;
  localparam [2:0] K_BUF_RD  = 3'h2;
  localparam [2:0] K_BUF_WR  = 3'h3;
  localparam [2:0] K_PROG    = 3'h4;

  localparam [1:0] PS_IDLE   = 2'h0;
  localparam [1:0] PS_ERASE  = 2'h1;
  localparam [1:0] PS_PROG   = 2'h2;
  localparam [1:0] PS_WAIT   = 2'h3;

  // --------------------------------------------------------------------------
  // Address field helpers
  // --------------------------------------------------------------------------
  function [9:0] f_page;
    input [23:0] a;
    input        m256;
    begin
      if (m256) begin
        f_page = a[`PG256_MSB:`PG256_LSB];
      end else begin
        f_page = a[`PG264_MSB:`PG264_LSB];
      end
    end
  endfunction

  function [8:0] f_off;
    input [23:0] a;
    input        m256;
    begin
      if (m256) begin
        f_off = {1'b0, a[`OFF256_MSB:0]};
      end else begin
        f_off = a[`OFF264_MSB:0];
      end
    end
  endfunction

  function [8:0] f_last;
    input m256;
    begin
      f_last = m256 ? `LAST_OFF_256 : `LAST_OFF_264;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pins into the mclk domain
  // --------------------------------------------------------------------------
  wire cs_n_s;
  wire cs_rise;
  wire sck_rise;
  wire sck_fall;
  wire si_s;
  wire cfg_256_s;

  spi_pin_sync u_sync (
    .mclk      (mclk),
    .srst      (srst),
    .cs_n      (cs_n),
    .sck       (sck),
    .si        (si),
    .cfg_256   (page_size_256),
    .cs_n_s    (cs_n_s),
    .cs_rise   (cs_rise),
    .sck_rise  (sck_rise),
    .sck_fall  (sck_fall),
    .si_s      (si_s),
    .cfg_256_s (cfg_256_s)
  );

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg [7:0]  buf_mem [0:`BUF_DEPTH-1];
  reg [2:0]  st_reg;
  reg [2:0]  kind_reg;
  reg [2:0]  dummy_reg;
  reg [2:0]  bit_reg;
  reg [2:0]  cnt_reg;
  reg [6:0]  in_reg;
  reg [15:0] addr_sh_reg;
  reg [9:0]  page_reg;
  reg [8:0]  off_reg;
  reg [7:0]  out_reg;
  reg        so_reg;
  reg        so_oe_reg;
  reg        m256_reg;
  reg [1:0]  ld_reg;
  reg [7:0]  buf_q_reg;
  reg [18:0] arr_addr_reg;
  reg        arr_rd_reg;
  reg        arr_wr_reg;
  reg [7:0]  arr_wd_reg;
  reg [1:0]  ps_reg;
  reg [9:0]  prog_page_reg;
  reg [8:0]  walk_reg;
  reg        phase_reg;
  reg [31:0] ep_cnt_reg;
  reg        wr_chk_reg;
  reg        epe_reg;
  reg [7:0]  prog_q_reg;

  wire [7:0]  byte_in   = {in_reg, si_s};
  wire        byte_done = sck_rise && (bit_reg == 3'h7);
  wire [23:0] full_addr = {addr_sh_reg, byte_in};
  wire        is_read   = (kind_reg == K_ARRAY) || (kind_reg == K_PAGE) ||
                          (kind_reg == K_BUF_RD);
  wire        busy_w    = (ps_reg != PS_IDLE);

  // Address of the next byte to fetch: freshly decoded at the end of the
  // address phase, otherwise the running pointer.
  reg  [9:0]  fa_page;
  reg  [8:0]  fa_off;
  reg  [2:0]  next_st;
  reg         fetch;
  reg         last_byte;

  always @* begin
    fa_page   = page_reg;
    fa_off    = off_reg;
    next_st   = st_reg;
    fetch     = 1'b0;
    last_byte = 1'b0;
    if (st_reg == ST_ADDR && cnt_reg == {1'b0, `ADDR_LAST_BYTE}) begin
      fa_page = f_page(full_addr, m256_reg);
      fa_off  = f_off(full_addr, m256_reg);
    end
    last_byte = (fa_off == f_last(m256_reg));
    if (byte_done) begin
      case (st_reg)
        ST_ADDR: begin
          if (cnt_reg == {1'b0, `ADDR_LAST_BYTE}) begin
            next_st = (dummy_reg == `DUMMY_NONE) ? ST_DATA : ST_DUMMY;
            fetch   = (dummy_reg == `DUMMY_NONE) && is_read;
          end
        end
        ST_DUMMY: begin
          if (cnt_reg == dummy_reg - 3'h1) begin
            next_st = ST_DATA;
            fetch   = is_read;
          end
        end
        ST_DATA: begin
          fetch = is_read;
        end
        default: begin
          next_st = st_reg;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Serial command engine
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (srst) begin
      st_reg      <= ST_OPCODE;
      kind_reg    <= K_ARRAY;
      dummy_reg   <= `DUMMY_NONE;
      bit_reg     <= 3'h0;
      cnt_reg     <= 3'h0;
      in_reg      <= 7'h00;
      addr_sh_reg <= 16'h0000;
      page_reg    <= 10'h000;
      off_reg     <= 9'h000;
      out_reg     <= 8'h00;
      so_reg      <= `SO_RESET;
      so_oe_reg   <= 1'b0;
      m256_reg    <= `CFG_256_RESET;
      ld_reg      <= 2'h0;
      buf_q_reg   <= 8'h00;
      arr_rd_reg  <= 1'b0;
    end else begin
      arr_rd_reg <= 1'b0;
      ld_reg     <= {1'b0, ld_reg[1]};
      if (cs_n_s) begin
        // Frame over: abandon the command and float the output
        st_reg    <= ST_OPCODE;
        bit_reg   <= 3'h0;
        cnt_reg   <= 3'h0;
        so_oe_reg <= 1'b0;
        ld_reg    <= 2'h0;
        // Page size is only taken between frames so a command never sees
        // its address layout change half way through
        m256_reg  <= cfg_256_s;
      end else begin
        if (sck_rise) begin
          in_reg  <= byte_in[6:0];
          bit_reg <= bit_reg + 3'h1;
        end
        if (byte_done) begin
          st_reg  <= next_st;
          cnt_reg <= (next_st != st_reg) ? 3'h0 : cnt_reg + 3'h1;
          case (st_reg)
            ST_OPCODE: begin
              st_reg  <= ST_ADDR;
              cnt_reg <= 3'h0;
              case (byte_in)
                `OP_LOW_POWER_READ: begin
                  kind_reg  <= K_ARRAY;
                  dummy_reg <= `DUMMY_NONE;
                end
                `OP_PAGE_READ: begin
                  kind_reg  <= K_PAGE;
                  dummy_reg <= `DUMMY_PAGE_READ;
                end
                `OP_BUF_READ_FAST: begin
                  kind_reg  <= K_BUF_RD;
                  dummy_reg <= `DUMMY_BUF_FAST;
                end
                `OP_BUF_READ_SLOW: begin
                  kind_reg  <= K_BUF_RD;
                  dummy_reg <= `DUMMY_NONE;
                end
                `OP_BUF_WRITE: begin
                  kind_reg  <= K_BUF_WR;
                  dummy_reg <= `DUMMY_NONE;
                end
                `OP_PROG_ERASE: begin
                  kind_reg  <= K_PROG;
                  dummy_reg <= `DUMMY_NONE;
                end
                default: begin
                  st_reg <= ST_IGNORE;
                end
              endcase
              // While programming nothing but waiting is accepted
              if (busy_w) begin
                st_reg <= ST_IGNORE;
              end
            end
            ST_ADDR: begin
              addr_sh_reg <= full_addr[15:0];
              if (cnt_reg == {1'b0, `ADDR_LAST_BYTE}) begin
                page_reg <= fa_page;
                off_reg  <= fa_off;
              end
            end
            ST_DATA: begin
              if (kind_reg == K_BUF_WR) begin
                off_reg <= last_byte ? 9'h000 : off_reg + 9'h001;
              end
            end
            default: begin
              st_reg <= next_st;
            end
          endcase
        end
        if (fetch) begin
          // Fetch the byte and step the pointer before its first bit falls
          if (kind_reg == K_BUF_RD) begin
            buf_q_reg <= buf_mem[fa_off];
            ld_reg    <= 2'h1;
          end else begin
            arr_rd_reg <= 1'b1;
            ld_reg     <= 2'h2;
          end
          page_reg <= fa_page;
          off_reg  <= last_byte ? 9'h000 : fa_off + 9'h001;
          if (last_byte && kind_reg == K_ARRAY) begin
            page_reg <= fa_page + 10'h001;
          end
        end
        if (ld_reg[0]) begin
          out_reg <= (kind_reg == K_BUF_RD) ? buf_q_reg : array_rd_data;
        end
        if (sck_fall && st_reg == ST_DATA && is_read) begin
          so_reg    <= out_reg[7];
          out_reg   <= {out_reg[6:0], 1'b0};
          so_oe_reg <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Buffer write port (reads above never touch it)
  // --------------------------------------------------------------------------
  always @(posedge mclk) begin
    if (!cs_n_s && byte_done && st_reg == ST_DATA && kind_reg == K_BUF_WR) begin
      buf_mem[off_reg] <= byte_in;
    end
  end

  // --------------------------------------------------------------------------
  // Self-timed erase then program of one page
  // --------------------------------------------------------------------------
  wire start_prog = cs_rise && st_reg == ST_DATA && kind_reg == K_PROG &&
                    bit_reg == 3'h0 && !busy_w;
  wire walk_last  = (walk_reg == f_last(m256_reg));

  always @(posedge mclk) begin
    if (srst) begin
      ps_reg        <= PS_IDLE;
      prog_page_reg <= 10'h000;
      walk_reg      <= 9'h000;
      phase_reg     <= 1'b0;
      ep_cnt_reg    <= 32'h0000_0000;
      arr_wr_reg    <= 1'b0;
      arr_wd_reg    <= 8'h00;
      wr_chk_reg    <= 1'b0;
      epe_reg       <= 1'b0;
    end else begin
      arr_wr_reg <= 1'b0;
      wr_chk_reg <= arr_wr_reg;
      if (busy_w && ep_cnt_reg != 32'h0000_0000) begin
        ep_cnt_reg <= ep_cnt_reg - 32'h0000_0001;
      end
      if (wr_chk_reg && array_wr_fail) begin
        epe_reg <= 1'b1;
      end
      case (ps_reg)
        PS_IDLE: begin
          if (start_prog) begin
            ps_reg        <= PS_ERASE;
            prog_page_reg <= page_reg;
            walk_reg      <= 9'h000;
            phase_reg     <= 1'b0;
            ep_cnt_reg    <= EP_CYCLES;
            epe_reg       <= 1'b0;
          end
        end
        PS_ERASE: begin
          arr_wr_reg <= 1'b1;
          arr_wd_reg <= `ERASED_BYTE;
          walk_reg   <= walk_last ? 9'h000 : walk_reg + 9'h001;
          if (walk_last) begin
            ps_reg <= PS_PROG;
          end
        end
        PS_PROG: begin
          // Two cycles a byte: read the buffer, then write it to the page
          phase_reg <= ~phase_reg;
          if (!phase_reg) begin
            prog_q_reg <= buf_mem[walk_reg];
          end else begin
            arr_wr_reg <= 1'b1;
            arr_wd_reg <= prog_q_reg;
            walk_reg   <= walk_reg + 9'h001;
            if (walk_last) begin
              ps_reg <= PS_WAIT;
            end
          end
        end
        PS_WAIT: begin
          // Busy spans the full erase-program time even when the walk ends early
          if (ep_cnt_reg <= 32'h0000_0001 && !wr_chk_reg) begin
            ps_reg <= PS_IDLE;
          end
        end
        default: begin
          ps_reg <= PS_IDLE;
        end
      endcase
    end
  end

  always @(posedge mclk) begin
    if (srst) begin
      arr_addr_reg <= 19'h00000;
    end else if (ps_reg == PS_ERASE || (ps_reg == PS_PROG && phase_reg)) begin
      arr_addr_reg <= {prog_page_reg, walk_reg};
    end else if (fetch && kind_reg != K_BUF_RD) begin
      arr_addr_reg <= {fa_page, fa_off};
    end
  end

  assign so                       = so_reg;
  assign so_oe                    = so_oe_reg;
  assign array_addr               = arr_addr_reg;
  assign array_rd_en              = arr_rd_reg;
  assign array_wr_en              = arr_wr_reg;
  assign array_wr_data            = arr_wd_reg;
  assign busy                     = busy_w;
  assign erase_program_error_flag = epe_reg;

endmodule

/* dv/flash_cmd_seq_sva.sv */
// Checker for the flash command sequencer, bound to its top module.
// Assumes a synchronous active-high reset and the mclk domain only.
`timescale 1ns/1ps

module flash_cmd_seq_sva #(
  parameter EP_CYCLES = 100000
) (
  input wire mclk,
  input wire srst,
  input wire cs_n,
  input wire so_oe,
  input wire array_rd_en,
  input wire array_wr_en,
  input wire array_wr_fail,
  input wire busy,
  input wire erase_program_error_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Busy length is counted here; a bare repetition cannot reach EP_CYCLES
  reg [31:0] busy_cnt_reg;
  always @(posedge mclk) begin
    if (srst || !busy) busy_cnt_reg <= 32'h0;
    else busy_cnt_reg <= busy_cnt_reg + 32'h1;
  end

  oe_off_a: assert property (cs_n [*6] |-> !so_oe)
    else $error("serial output still driven after select high");
  oe_cs_a: assert property ($rose(so_oe) |-> !cs_n && !busy)
    else $error("serial output enabled outside a frame");
  wr_busy_a: assert property (array_wr_en |-> busy)
    else $error("array written outside program cycle");
  busy_src_a: assert property ($rose(busy) |-> cs_n)
    else $error("program started while select low");
  ep_len_a: assert property ($fell(busy) |->
      busy_cnt_reg + 8 >= EP_CYCLES && busy_cnt_reg <= EP_CYCLES + 8)
    else $error("busy length differs from program time");
  flag_src_a: assert property ($rose(erase_program_error_flag) |->
      $past(array_wr_fail) || $past(array_wr_fail, 2))
    else $error("error flag set without failing byte");
  flag_clr_a: assert property ($rose(busy) |-> ##[0:1] !erase_program_error_flag)
    else $error("error flag not cleared at program start");
  rd_pulse_a: assert property (array_rd_en |=> !array_rd_en)
    else $error("array read strobe longer than one cycle");

  cover property ($fell(busy));
  cover property ($rose(so_oe));
  cover property ($rose(erase_program_error_flag));
endmodule

bind flash_cmd_seq flash_cmd_seq_sva #(.EP_CYCLES(EP_CYCLES)) u_flash_cmd_seq_sva (
  .mclk(mclk),
  .srst(srst),
  .cs_n(cs_n),
  .so_oe(so_oe),
  .array_rd_en(array_rd_en),
  .array_wr_en(array_wr_en),
  .array_wr_fail(array_wr_fail),
  .busy(busy),
  .erase_program_error_flag(erase_program_error_flag)
);

/* dv/spi_host.sv */
// Host model of the serial link: mode 0, eight mclk per link clock.
// Assumes mclk is the bench clock; all pins change by NBA at its rising edge.
`timescale 1ns/1ps

module spi_host (
  input  wire mclk,
  input  wire so,
  output reg  cs_n,
  output reg  sck,
  output reg  si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  task start;
    begin
      @(posedge mclk);
      cs_n <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask

  // Output is read at the end of the high half, well after the launching fall
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i--) begin
        si <= tx[i];
        repeat (4) @(posedge mclk);
        sck <= 1'b1;
        repeat (4) @(posedge mclk);
        rx[i] = so;
        sck <= 1'b0;
      end
    end
  endtask

  task stop;
    begin
      repeat (4) @(posedge mclk);
      cs_n <= 1'b1;
      si <= ~si;
      repeat (8) @(posedge mclk);
    end
  endtask
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the flash command sequencer with an array model.
// Assumes the sequencer sources under core/ and the host model in dv/.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end

module tb_top;
  reg         mclk;
  reg         srst;
  reg         page_size_256;
  reg  [7:0]  array_rd_data;
  reg         array_wr_fail;
  reg         fail_inject;
  wire        cs_n;
  wire        sck;
  wire        si;
  wire        so;
  wire        so_oe;
  // Released output reads as pulled up, so a late enable shows as a mismatch
  wire        so_pin = so_oe ? so : 1'b1;
  wire        array_rd_en;
  wire        array_wr_en;
  wire        busy;
  wire        ep_flag;
  wire [18:0] array_addr;
  wire [7:0]  array_wr_data;
  reg  [7:0]  mem [0:524287];
  reg  [7:0]  bufm [0:263];
  integer     num_errors;
  integer     compares;
  integer     k;
  reg  [7:0]  r;

  flash_cmd_seq #(.EP_CYCLES(1200)) u_flash_cmd_seq (
    .mclk(mclk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
    .page_size_256(page_size_256), .array_addr(array_addr), .array_rd_en(array_rd_en),
    .array_rd_data(array_rd_data), .array_wr_en(array_wr_en),
    .array_wr_data(array_wr_data), .array_wr_fail(array_wr_fail), .busy(busy),
    .erase_program_error_flag(ep_flag));

  spi_host u_spi_host (.mclk(mclk), .so(so_pin), .cs_n(cs_n), .sck(sck), .si(si));

  // Array model: one-cycle read, failure reported the cycle after a write
  always @(posedge mclk) begin
    if (array_rd_en) array_rd_data <= mem[array_addr];
    if (array_wr_en) mem[array_addr] <= array_wr_data;
    array_wr_fail <= array_wr_en & fail_inject;
  end

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task cmd(input [7:0] op, input [23:0] a, input integer nd);
    integer i;
    begin
      u_spi_host.start;
      u_spi_host.xfer(op, r);
      for (i = 2; i >= 0; i--) u_spi_host.xfer(a[i*8 +: 8], r);
      for (i = 0; i < nd; i++) u_spi_host.xfer(8'h00, r);
    end
  endtask

  task rd_chk(input [7:0] e);
    begin
      u_spi_host.xfer(8'ha5, r);
      `CHK("so byte", e, r)
    end
  endtask

  task stop;
    begin
      u_spi_host.stop;
      `CHK("so_oe", 1'b0, so_oe)
    end
  endtask

  task wait_idle;
    integer n;
    begin
      @(negedge mclk);
      `CHK("busy", 1'b1, busy)
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
        @(negedge mclk);
        n++;
      end
      `CHK("busy end", 1'b0, busy)
    end
  endtask

  task t_buffer;
    begin
      cmd(8'h84, 24'h0, 0);
      for (k = 0; k < 264; k++) begin
        bufm[k] = k[7:0] ^ 8'h5a;
        u_spi_host.xfer(bufm[k], r);
      end
      stop;
      cmd(8'h84, 24'd262, 0);
      for (k = 0; k < 3; k++) u_spi_host.xfer(8'hc3 + k[7:0], r);
      stop;
      bufm[262] = 8'hc3;
      bufm[263] = 8'hc4;
      bufm[0] = 8'hc5;
      cmd(8'hd4, 24'd262, 1);
      rd_chk(bufm[262]);
      rd_chk(bufm[263]);
      rd_chk(bufm[0]);
      stop;
      $display("test buffer done");
    end
  endtask

  task t_reads;
    begin
      cmd(8'h01, {5'h0, 10'd5, 9'd262}, 0);
      rd_chk(mem[{10'd5, 9'd262}]);
      rd_chk(mem[{10'd5, 9'd263}]);
      rd_chk(mem[{10'd6, 9'd0}]);
      stop;
      cmd(8'h01, {5'h0, 10'd1023, 9'd263}, 0);
      rd_chk(mem[{10'd1023, 9'd263}]);
      rd_chk(mem[0]);
      stop;
      @(posedge mclk);
      page_size_256 <= 1'b1;
      cmd(8'hd2, {6'h0, 10'd3, 8'd255}, 4);
      rd_chk(mem[{10'd3, 9'd255}]);
      rd_chk(mem[{10'd3, 9'd0}]);
      stop;
      cmd(8'hd1, {16'hffff, 8'd255}, 0);
      rd_chk(bufm[255]);
      rd_chk(bufm[0]);
      stop;
      @(posedge mclk);
      page_size_256 <= 1'b0;
      cmd(8'hd1, 24'd1, 0);
      rd_chk(bufm[1]);
      stop;
      $display("test reads done");
    end
  endtask

  task t_program;
    begin
      cmd(8'h83, {5'h1f, 10'd7, 9'h1ab}, 0);
      stop;
      wait_idle;
      for (k = 0; k < 264; k++) `CHK("page byte", bufm[k], mem[{10'd7, k[8:0]}])
      `CHK("error flag", 1'b0, ep_flag)
      fail_inject = 1'b1;
      cmd(8'h83, {5'h0, 10'd8, 9'h0}, 0);
      stop;
      wait_idle;
      `CHK("error flag", 1'b1, ep_flag)
      fail_inject = 1'b0;
      @(posedge mclk);
      page_size_256 <= 1'b1;
      cmd(8'h83, {6'h3f, 10'd9, 8'hab}, 0);
      stop;
      wait_idle;
      `CHK("page byte", bufm[0], mem[{10'd9, 9'd0}])
      `CHK("page byte", bufm[255], mem[{10'd9, 9'd255}])
      `CHK("page tail", 8'h13, mem[{10'd9, 9'd256}])
      `CHK("error flag", 1'b0, ep_flag)
      $display("test program done");
    end
  endtask

  task print_verdict;
    begin
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  initial begin
    num_errors = 0;
    compares = 0;
    srst = 1'b1;
    page_size_256 = 1'b0;
    fail_inject = 1'b0;
    for (k = 0; k < 524288; k++) mem[k] = k[7:0] ^ k[15:8] ^ {5'h0, k[18:16]};
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_buffer;
    t_reads;
    t_program;
    print_verdict;
  end

  // Whole run is near 25000 cycles; over twice that means a hang
  initial begin
    repeat (60000) @(posedge mclk);
    num_errors++;
    $display("[ERR] watchdog exp done got hang");
    print_verdict;
  end
endmodule
